/* File: include/dmr_defines.svh */
`ifndef DMR_DEFINES_SVH
`define DMR_DEFINES_SVH

// Command codes of the status-returning memory fetch.
`define DMR_CMD_FETCH_STATUS_BYTE 8'h31
`define DMR_CMD_FETCH_STATUS_WORD 8'h35
`define DMR_CMD_FETCH_STATUS_LONG 8'h39
// Command codes of the plain memory fetch.
`define DMR_CMD_FETCH_BYTE        8'h30
`define DMR_CMD_FETCH_WORD        8'h34
`define DMR_CMD_FETCH_LONG        8'h38

// Index of the last of the three address packets per command.
`define DMR_ADDR_LAST_IDX         2'h2
// Mask that clears the two low address bits of a longword access.
`define DMR_LONG_ALIGN_MASK       24'hfffffc
// Byte counts of each access size.
`define DMR_BYTES_BYTE            3'h1
`define DMR_BYTES_WORD            3'h2
`define DMR_BYTES_LONG            3'h4
// Left shifts that put the most significant returned byte at the top, and the shift per byte sent.
`define DMR_SHIFT_BYTE            5'h18
`define DMR_SHIFT_WORD            5'h10
`define DMR_SHIFT_LONG            5'h00
`define DMR_BYTE_SHIFT            5'h08

`endif

/* File: include/dmr_pkg.sv */
`include "dmr_defines.svh"

package dmr_pkg;

	// Access size of one memory fetch.
	typedef enum logic [1:0] {
		DMR_SIZE_BYTE = 2'h0,
		DMR_SIZE_WORD = 2'h1,
		DMR_SIZE_LONG = 2'h2
	} dmr_size_type;

	// Command sequencer states, one-hot.
	typedef enum logic [6:0] {
		DMR_ST_IDLE  = 7'h01,
		DMR_ST_ADDR  = 7'h02,
		DMR_ST_READ  = 7'h04,
		DMR_ST_ACK   = 7'h08,
		DMR_ST_STAT  = 7'h10,
		DMR_ST_DATA  = 7'h20,
		DMR_ST_SPARE = 7'h40
	} dmr_state_type;

	// Read request toward the device memory bus.
	typedef struct packed {
		logic         valid;
		dmr_size_type size;
		logic [23:0]  addr;
	} dmr_mem_req_type;

	// Byte returned toward the link serializer.
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} dmr_tx_type;

endpackage : dmr_pkg

/* File: src/dmr_memory_fetch.sv */
`include "dmr_defines.svh"

module dmr_memory_fetch (
	input  wire logic                     clk_sys,      // System clock, 100 MHz.
	input  wire logic                     rst_n,        // Asynchronous reset, active low.
	input  wire logic                     rx_valid,     // One received link byte this cycle.
	input  wire logic [7:0]               rx_data,      // Received link byte.
	input  wire logic                     ack_enable,   // Acknowledge signalling enabled.
	input  wire logic [7:0]               status_low,   // Live low byte of the debug status.
	output dmr_pkg::dmr_mem_req_type      mem_req,      // Memory read request, held until done.
	input  wire logic                     mem_done,     // Memory read finished, one-cycle pulse.
	input  wire logic [31:0]              mem_rdata,    // Read data, right justified.
	output dmr_pkg::dmr_tx_type           tx,           // Byte offered to the link.
	input  wire logic                     tx_ready,     // Link takes the offered byte.
	output logic                          ack_pulse,    // One-cycle acknowledge pulse request.
	output logic                          busy          // Command in progress.
);

	dmr_pkg::dmr_state_type state;
	dmr_pkg::dmr_state_type next_state;
	dmr_pkg::dmr_size_type  size;
	logic                   with_status;
	logic [1:0]             addr_idx;
	logic [23:0]            addr_shift;
	logic [31:0]            data_shift;
	logic [2:0]             bytes_left;
	logic                   cmd_known;
	logic                   cmd_status;
	dmr_pkg::dmr_size_type  cmd_size;
	logic                   tx_taken;
	logic [3:0]             cmd_decoded;

	// Decodes a command byte into validity, status option and size.
	function automatic logic [3:0] dmr_decode(input logic [7:0] cmd);
		logic [3:0] r;
		r = 4'h0;
		case (cmd)
			`DMR_CMD_FETCH_STATUS_BYTE: r = {1'b1, 1'b1, dmr_pkg::DMR_SIZE_BYTE};
			`DMR_CMD_FETCH_STATUS_WORD: r = {1'b1, 1'b1, dmr_pkg::DMR_SIZE_WORD};
			`DMR_CMD_FETCH_STATUS_LONG: r = {1'b1, 1'b1, dmr_pkg::DMR_SIZE_LONG};
			`DMR_CMD_FETCH_BYTE:        r = {1'b1, 1'b0, dmr_pkg::DMR_SIZE_BYTE};
			`DMR_CMD_FETCH_WORD:        r = {1'b1, 1'b0, dmr_pkg::DMR_SIZE_WORD};
			`DMR_CMD_FETCH_LONG:        r = {1'b1, 1'b0, dmr_pkg::DMR_SIZE_LONG};
			default:                    r = 4'h0;
		endcase
		return r;
	endfunction : dmr_decode

	// Number of data bytes returned for an access size.
	function automatic logic [2:0] dmr_byte_count(input dmr_pkg::dmr_size_type sz);
		case (sz)
			dmr_pkg::DMR_SIZE_WORD: return `DMR_BYTES_WORD;
			dmr_pkg::DMR_SIZE_LONG: return `DMR_BYTES_LONG;
			default:                return `DMR_BYTES_BYTE;
		endcase
	endfunction : dmr_byte_count

	// Left shift that brings the most significant data byte to bits 31:24.
	function automatic logic [4:0] dmr_msb_shift(input dmr_pkg::dmr_size_type sz);
		case (sz)
			dmr_pkg::DMR_SIZE_WORD: return `DMR_SHIFT_WORD;
			dmr_pkg::DMR_SIZE_LONG: return `DMR_SHIFT_LONG;
			default:                return `DMR_SHIFT_BYTE;
		endcase
	endfunction : dmr_msb_shift

	// Command decode and the link handshake term.
	// The decode result is held in a net, since a function result cannot be part-selected.
	assign cmd_decoded             = dmr_decode(rx_data);
	assign {cmd_known, cmd_status} = cmd_decoded[3:2];
	assign cmd_size                = dmr_pkg::dmr_size_type'(cmd_decoded[1:0]);
	assign tx_taken                = tx.valid & tx_ready;

	// Next state. Link bytes during the turnaround or the reply are ignored,
	// since the host is not allowed to talk while the target owns the line.
	always_comb begin
		next_state = state;
		case (state)
			dmr_pkg::DMR_ST_IDLE: begin
				if (rx_valid && cmd_known) begin
					next_state = dmr_pkg::DMR_ST_ADDR;
				end
			end
			dmr_pkg::DMR_ST_ADDR: begin
				if (rx_valid && addr_idx == `DMR_ADDR_LAST_IDX) begin
					next_state = dmr_pkg::DMR_ST_READ;
				end
			end
			dmr_pkg::DMR_ST_READ: begin
				if (mem_done) begin
					if (ack_enable) begin
						next_state = dmr_pkg::DMR_ST_ACK;
					end else if (with_status) begin
						next_state = dmr_pkg::DMR_ST_STAT;
					end else begin
						next_state = dmr_pkg::DMR_ST_DATA;
					end
				end
			end
			dmr_pkg::DMR_ST_ACK: begin
				next_state = with_status ? dmr_pkg::DMR_ST_STAT : dmr_pkg::DMR_ST_DATA;
			end
			dmr_pkg::DMR_ST_STAT: begin
				if (tx_taken) begin
					next_state = dmr_pkg::DMR_ST_DATA;
				end
			end
			dmr_pkg::DMR_ST_DATA: begin
				if (tx_taken && bytes_left == `DMR_BYTES_BYTE) begin
					next_state = dmr_pkg::DMR_ST_IDLE;
				end
			end
			default: next_state = dmr_pkg::DMR_ST_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= dmr_pkg::DMR_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Command attributes latched from the command byte.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			size        <= dmr_pkg::DMR_SIZE_BYTE;
			with_status <= 1'b0;
		end else if (state == dmr_pkg::DMR_ST_IDLE && rx_valid && cmd_known) begin
			size        <= cmd_size;
			with_status <= cmd_status;
		end
	end

	// Address assembly, most significant packet first.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			addr_idx   <= 2'h0;
			addr_shift <= 24'h000000;
		end else if (state == dmr_pkg::DMR_ST_IDLE) begin
			addr_idx <= 2'h0;
		end else if (state == dmr_pkg::DMR_ST_ADDR && rx_valid) begin
			addr_shift <= {addr_shift[15:0], rx_data};
			addr_idx   <= addr_idx + 2'h1;
		end
	end

	// Memory request, raised on the last address packet and held until done.
	// The read happens inside the host's turnaround wait.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_req <= '0;
		end else if (state == dmr_pkg::DMR_ST_ADDR && rx_valid && addr_idx == `DMR_ADDR_LAST_IDX) begin
			mem_req.valid <= 1'b1;
			mem_req.size  <= size;
			if (size == dmr_pkg::DMR_SIZE_LONG) begin
				mem_req.addr <= {addr_shift[15:0], rx_data} & `DMR_LONG_ALIGN_MASK;
			end else begin
				mem_req.addr <= {addr_shift[15:0], rx_data};
			end
		end else if (state == dmr_pkg::DMR_ST_READ && mem_done) begin
			mem_req.valid <= 1'b0;
		end
	end

	// Read data held left aligned and shifted out a byte at a time.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			data_shift <= 32'h00000000;
			bytes_left <= 3'h0;
		end else if (state == dmr_pkg::DMR_ST_READ && mem_done) begin
			data_shift <= mem_rdata << dmr_msb_shift(size);
			bytes_left <= dmr_byte_count(size);
		end else if (state == dmr_pkg::DMR_ST_DATA && tx_taken) begin
			data_shift <= data_shift << `DMR_BYTE_SHIFT;
			bytes_left <= bytes_left - 3'h1;
		end
	end

	// Link byte register. The status byte is caught in the cycle the read
	// completes, so it shows the state after the access and not before it.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx <= '0;
		end else if (state == dmr_pkg::DMR_ST_READ && mem_done) begin
			tx.valid <= ~ack_enable;
			tx.data  <= with_status ? status_low
				: 8'((mem_rdata << dmr_msb_shift(size)) >> `DMR_SHIFT_BYTE);
		end else if (state == dmr_pkg::DMR_ST_ACK) begin
			tx.valid <= 1'b1;
		end else if (state == dmr_pkg::DMR_ST_STAT && tx_taken) begin
			tx.data <= data_shift[31:24];
		end else if (state == dmr_pkg::DMR_ST_DATA && tx_taken) begin
			tx.valid <= (bytes_left != `DMR_BYTES_BYTE);
			tx.data  <= data_shift[23:16];
		end
	end

	// Acknowledge pulse, one cycle, issued before any byte is offered.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_pulse <= 1'b0;
		end else begin
			ack_pulse <= (state == dmr_pkg::DMR_ST_READ) && mem_done && ack_enable;
		end
	end

	// Busy flag for the surrounding debug controller.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
		end else begin
			busy <= (next_state != dmr_pkg::DMR_ST_IDLE);
		end
	end

endmodule : dmr_memory_fetch

/* File: verif/dmr_memory_fetch_monitor.sv */
module dmr_memory_fetch_monitor (
	input wire logic                     clk_sys,    // Clock.
	input wire logic                     rst_n,      // Reset.
	input wire logic                     rx_valid,   // Byte strobe.
	input wire logic [7:0]               rx_data,    // Byte.
	input wire logic                     ack_enable, // Ack on.
	input wire logic [7:0]               status_low, // Status.
	input wire dmr_pkg::dmr_mem_req_type mem_req,    // Request.
	input wire logic                     mem_done,   // Done.
	input wire logic [31:0]              mem_rdata,  // Data.
	input wire dmr_pkg::dmr_tx_type      tx,         // Offered byte.
	input wire logic                     tx_ready,   // Taken.
	input wire logic                     ack_pulse,  // Ack pulse.
	input wire logic                     busy        // Busy.
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// A finished read is a live request meeting its done pulse.
	sequence s_done; mem_req.valid && mem_done; endsequence
	property p_align; mem_req.valid && mem_req.size == dmr_pkg::DMR_SIZE_LONG |-> mem_req.addr[1:0] == 2'h0; endproperty
	a_align: assert property (p_align) else $error("long fetch not aligned");
	property p_hold; mem_req.valid && !mem_done |=> $stable(mem_req); endproperty
	a_hold: assert property (p_hold) else $error("request moved before done");
	property p_drop; s_done |=> !mem_req.valid; endproperty
	a_drop: assert property (p_drop) else $error("request stayed after done");
	property p_quiet; mem_req.valid |-> !tx.valid && !ack_pulse; endproperty
	a_quiet: assert property (p_quiet) else $error("reply before read done");
	property p_ack; s_done ##0 ack_enable |=> ack_pulse ##1 (tx.valid && !ack_pulse); endproperty
	a_ack: assert property (p_ack) else $error("ack pulse not ahead of bytes");
	property p_noack; s_done ##0 !ack_enable |=> tx.valid && !ack_pulse; endproperty
	a_noack: assert property (p_noack) else $error("reply late or stray ack");
	property p_txhold; tx.valid && !tx_ready |=> tx.valid && $stable(tx.data); endproperty
	a_txhold: assert property (p_txhold) else $error("byte dropped before taken");
	property p_start; !busy && rx_valid && rx_data == 8'h39 |=> busy; endproperty
	a_start: assert property (p_start) else $error("command not taken");
endmodule : dmr_memory_fetch_monitor

bind dmr_memory_fetch dmr_memory_fetch_monitor u_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
	.rx_valid(rx_valid), .rx_data(rx_data), .ack_enable(ack_enable), .status_low(status_low),
	.mem_req(mem_req), .mem_done(mem_done), .mem_rdata(mem_rdata), .tx(tx), .tx_ready(tx_ready),
	.ack_pulse(ack_pulse), .busy(busy));

/* File: verif/dmr_mem_model.sv */
module dmr_mem_model (
	input  wire logic                     clk_sys,   // Clock.
	input  wire logic                     rst_n,     // Reset.
	input  wire logic [2:0]               delay,     // Wait cycles.
	input  wire dmr_pkg::dmr_mem_req_type mem_req,   // Request.
	output logic                          mem_done,  // Done pulse.
	output logic [31:0]                   mem_rdata, // Data.
	output logic [7:0]                    status_low // Status.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]  wait_cnt;
	logic [31:0] word;
	// Data and status are inverted outside the done cycle, so a stale capture shows.
	assign word = {mem_req.addr[7:0], mem_req.addr} ^ 32'h5ac3_96e1;
	assign mem_rdata = mem_done ? word : ~word;
	assign status_low = mem_done ? word[15:8] : ~word[15:8];
	// The read lasts a chosen number of cycles before done.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt <= 4'h0;
			mem_done <= 1'b0;
		end else begin
			mem_done <= mem_req.valid && !mem_done && wait_cnt == {1'b0, delay};
			wait_cnt <= (mem_req.valid && !mem_done) ? wait_cnt + 4'h1 : 4'h0;
		end
	end
endmodule : dmr_mem_model

/* File: verif/dmr_memory_fetch_tb.sv */
module dmr_memory_fetch_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                     clk_sys, rst_n, rx_valid, ack_enable, mem_done, tx_ready, ack_pulse, busy;
	logic [7:0]               rx_data, status_low;
	logic [31:0]              mem_rdata;
	logic [2:0]               delay;
	dmr_pkg::dmr_mem_req_type mem_req;
	dmr_pkg::dmr_tx_type      tx;
	logic [7:0]               codes [6] = '{8'h31, 8'h35, 8'h39, 8'h30, 8'h34, 8'h38};
	int                       n_fail = 0, check_count = 0, cycles = 0, i;
	dmr_memory_fetch DUT (.clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
		.ack_enable(ack_enable), .status_low(status_low), .mem_req(mem_req), .mem_done(mem_done),
		.mem_rdata(mem_rdata), .tx(tx), .tx_ready(tx_ready), .ack_pulse(ack_pulse), .busy(busy));
	dmr_mem_model u_mem (.clk_sys(clk_sys), .rst_n(rst_n), .delay(delay), .mem_req(mem_req),
		.mem_done(mem_done), .mem_rdata(mem_rdata), .status_low(status_low));
	// The clock toggles every half period.
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// A hang is cut short well beyond the expected run length.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Sends command and address back to back plus a stray byte, then takes the reply with random stalls.
	task automatic fetch(input logic [7:0] cmd, input logic [23:0] addr, input logic ack);
		logic [7:0]  pkt [4];
		logic [23:0] al;
		logic [31:0] w;
		logic [1:0]  sz;
		logic        seen;
		int          nb, k, t;
		pkt = '{cmd, addr[23:16], addr[15:8], addr[7:0]};
		al = cmd[3] ? {addr[23:2], 2'h0} : addr;
		sz = cmd[3] ? 2'h2 : {1'b0, cmd[2]};
		nb = cmd[3] ? 4 : cmd[2] ? 2 : 1;
		w = {al[7:0], al} ^ 32'h5ac3_96e1;
		ack_enable = ack;
		rx_valid = 1'b1;
		for (k = 0; k < 5; k++) begin
			rx_data = (k < 4) ? pkt[k] : 8'h39;
			@(posedge clk_sys);
			#1;
		end
		rx_valid = 1'b0;
		seen = 1'b0;
		k = cmd[0] ? -1 : 0;
		for (t = 0; t < 200 && k < nb; t++) begin
			tx_ready = 1'($urandom_range(0, 1));
			@(posedge clk_sys);
			seen |= ack_pulse;
			if (mem_req.valid) check("fetch request", {sz, al}, {mem_req.size, mem_req.addr});
			if (tx.valid && tx_ready) begin
				check("ack first", ack, seen);
				check("reply byte", k < 0 ? w[15:8] : w[8 * (nb - 1 - k) +: 8], tx.data);
				k++;
			end
			#1;
		end
		check("reply count", nb, k);
		@(posedge clk_sys);
		#1;
		check("idle after reply", 2'h0, {busy, tx.valid});
	endtask : fetch
	task automatic give_verdict();
		if (n_fail == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict
	// Reset, an unknown code, every code at the top address, random traffic, then a reset mid-fetch.
	initial begin
		void'($urandom(51596));
		rst_n = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		ack_enable = 1'b0;
		tx_ready = 1'b0;
		delay = 3'h0;
		repeat (6) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		rx_valid = 1'b1;
		rx_data = 8'h55;
		@(posedge clk_sys);
		#1;
		rx_valid = 1'b0;
		@(posedge clk_sys);
		#1;
		check("unknown code ignored", 1'b0, busy);
		for (i = 0; i < 6; i++) begin
			delay = 3'(i + 2);
			fetch(codes[i], 24'hffffff, i[0]);
		end
		repeat (60) begin
			delay = 3'($urandom_range(0, 7));
			fetch(codes[$urandom_range(0, 5)], 24'($urandom), 1'($urandom_range(0, 1)));
		end
		// A reset cut into a fetch that waits on memory must clear every output at once.
		delay = 3'h7;
		rx_valid = 1'b1;
		rx_data = 8'h39;
		repeat (4) @(posedge clk_sys);
		#1;
		rx_valid = 1'b0;
		rst_n = 1'b0;
		#1;
		check("request in reset", 32'h0, 32'(mem_req));
		check("reply in reset", 32'h0, {21'h0, tx, ack_pulse, busy});
		@(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		fetch(codes[5], 24'h123457, 1'b1);
		give_verdict();
	end
endmodule : dmr_memory_fetch_tb
